// *** io_channel_block_transfer.sv ***
// Channel input/output block transfer engine
`timescale 1ns/1ps
`include "io_channel_defs.svh"

// What this block does
// - Peripheral output register loads from storage
// - Three 30-bit driver groups, four channels each
// - Intercomputer register drives special channels 0-1
// - Output channels 0-13, highest served first
// - Per-channel gated input, opened by grant
// - Highest pending input channel granted first
// - Channels 0 and 1 intercomputer, lowest priority
// - Input words go straight into storage
// - Request, acknowledge handshake per channel word
// - Busy test refuses activation of busy channel
// - One control word per channel and direction
// - Deactivate channel when control word ends
// - 15-bit storage address loaded per access
// - Data register split in two halves
// - Destructive read restored within 8 us
// - Control word restore adds one to lower half
// - Halves equal after increment ends transfer
// - Block runs without program after activation
// - Output channels may carry function words
module io_channel_block_transfer #(
    parameter int          NCHAN     = `IOC_NCHAN,
    parameter int          STORE_CYC = `IOC_STORE_CYC,
    parameter logic [14:0] CW_BASE   = `IOC_CW_BASE
) (
    // Clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  rstn_i,
    // Program side
    input  wire logic                  act_valid_i,
    input  wire logic                  act_out_i,
    input  wire logic [3:0]            act_chan_i,
    input  wire logic                  act_func_i,
    output logic                       act_taken_o,
    output logic                       act_refused_o,
    output logic [NCHAN-1:0]           in_busy_o,
    output logic [NCHAN-1:0]           out_busy_o,
    // Input channels
    input  wire logic [NCHAN-1:0]      in_req_i,
    input  io_channel_pkg::word_t      in_data_i [NCHAN],
    output logic [NCHAN-1:0]           in_ack_o,
    // Output channels
    input  wire logic [NCHAN-1:0]      out_req_i,
    output logic [NCHAN-1:0]           out_ack_o,
    output logic [NCHAN-1:0]           out_func_o,
    output io_channel_pkg::word_t      periph_grp_o [`IOC_NGROUPS],
    output io_channel_pkg::word_t      ic_data_o,
    // Storage
    output io_channel_pkg::half_t      mem_addr_o,
    output logic                       mem_rd_o,
    output logic                       mem_wr_o,
    output io_channel_pkg::word_t      mem_wdata_o,
    input  io_channel_pkg::word_t      mem_rdata_i
);
    import io_channel_pkg::*;

    localparam int CNT_W = $clog2(STORE_CYC + 1);
    localparam int PW    = 2 * NCHAN;
    localparam logic [CNT_W-1:0] CNT_CAP  = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_WR   = CNT_W'(STORE_CYC / 2 - 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STORE_CYC - 1);

    xfer_state_t        state_reg;
    logic [CNT_W-1:0]   cnt_reg;
    logic [3:0]         gchan_reg;
    logic               gin_reg;
    logic               last_reg;
    half_t              cur_addr_reg;
    half_t              data_upper_half_reg;
    half_t              data_lower_half_reg;
    half_t              mem_addr_reg;
    logic               mem_rd_reg;
    logic               mem_wr_reg;
    word_t              mem_wdata_reg;
    word_t              peripheral_output_reg;
    word_t              intercomputer_output_reg;
    word_t              periph_drv_reg [`IOC_NGROUPS];
    logic [NCHAN-1:0]   in_act_reg;
    logic [NCHAN-1:0]   out_act_reg;
    logic [NCHAN-1:0]   in_ack_reg;
    logic [NCHAN-1:0]   out_ack_reg;
    logic [NCHAN-1:0]   out_func_reg;
    logic               act_taken_reg;
    logic               act_refused_reg;

    logic [NCHAN-1:0]   in_req_lvl;
    logic [NCHAN-1:0]   out_req_lvl;
    word_t              in_word [NCHAN];
    logic [PW-1:0]      pend;

    // Per-channel synchronisers; the far end keeps request up until acked
    // Three stages: the first may go metastable, the last two must agree
    genvar g;
    generate
        for (g = 0; g < NCHAN; g++) begin : g_chan
            logic [2:0] ireq_sync;
            logic [2:0] oreq_sync;
            logic       ireq_lvl;
            logic       oreq_lvl;
            word_t      d1;
            word_t      d2;
            word_t      d3;
            always_ff @(posedge clk_sys_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    ireq_sync <= 3'h0;
                    oreq_sync <= 3'h0;
                    ireq_lvl  <= 1'b0;
                    oreq_lvl  <= 1'b0;
                end else begin
                    ireq_sync <= {ireq_sync[1:0], in_req_i[g]};
                    oreq_sync <= {oreq_sync[1:0], out_req_i[g]};
                    if (ireq_sync[2] == ireq_sync[1])
                        ireq_lvl <= ireq_sync[2];
                    if (oreq_sync[2] == oreq_sync[1])
                        oreq_lvl <= oreq_sync[2];
                end
            end
            // Data is held steady by the handshake, so stage three is used
            always_ff @(posedge clk_sys_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    d1 <= '0;
                    d2 <= '0;
                    d3 <= '0;
                end else begin
                    d1 <= in_data_i[g];
                    d2 <= d1;
                    d3 <= d2;
                end
            end
            assign in_req_lvl[g]  = ireq_lvl;
            assign out_req_lvl[g] = oreq_lvl;
            assign in_word[g]     = d3;
            // Input ranks above output at the same channel number
            assign pend[2*g+1] = in_act_reg[g] & ireq_lvl & ~in_ack_reg[g];
            assign pend[2*g]   = out_act_reg[g] & oreq_lvl & ~out_ack_reg[g];
        end
    endgenerate

    // Highest set bit wins, so higher channel numbers always come first
    function automatic logic [4:0] top_idx(input logic [PW-1:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < PW; i++) begin
            if (v[i])
                r = 5'(i);
        end
        return r;
    endfunction

    wire         any_pend   = |pend;
    wire [4:0]   top        = top_idx(pend);
    wire         in_idle    = (state_reg == ST_IDLE);
    wire         start_cw   = in_idle & any_pend;
    wire         in_cw      = (state_reg == ST_CW);
    wire         in_data    = (state_reg == ST_DATA);
    wire         cap_now    = ~in_idle & (cnt_reg == CNT_CAP);
    wire         wr_now     = ~in_idle & (cnt_reg == CNT_WR);
    wire         acc_end    = ~in_idle & (cnt_reg == CNT_LAST);
    wire         cw_end     = in_cw & acc_end;
    wire         data_end   = in_data & acc_end;
    wire half_t  cw_addr    = CW_BASE + 15'(top);
    wire half_t  rd_lower   = mem_rdata_i[`IOC_HALF_W-1:0];
    wire half_t  rd_upper   = mem_rdata_i[`IOC_WORD_W-1:`IOC_HALF_W];
    wire half_t  lower_inc  = rd_lower + 15'h0001;
    wire         hit_end    = (lower_inc == rd_upper);
    wire word_t  in_gated   = in_word[gchan_reg];
    wire         is_ic      = (gchan_reg < 4'(`IOC_IC_CHANS));
    wire [NCHAN-1:0] gsel   = NCHAN'(1) << gchan_reg;
    wire [NCHAN-1:0] in_done  = (data_end & gin_reg) ? gsel : '0;
    wire [NCHAN-1:0] out_done = (data_end & ~gin_reg) ? gsel : '0;
    wire [NCHAN-1:0] fin_sel  = last_reg ? (in_done | out_done) : '0;
    wire [NCHAN-1:0] asel     = NCHAN'(1) << act_chan_i;
    wire         act_range  = (act_chan_i < 4'(NCHAN));
    wire         act_busy   = act_out_i ? |(out_act_reg & asel) : |(in_act_reg & asel);
    wire         act_ok     = act_valid_i & act_range & ~act_busy;
    wire [NCHAN-1:0] in_set   = (act_ok & ~act_out_i) ? asel : '0;
    wire [NCHAN-1:0] out_set  = (act_ok & act_out_i) ? asel : '0;

    // Capture points; the read word stands only in the cycle after the strobe
    wire         cap_cw     = cap_now & in_cw;
    wire         cap_in     = cap_now & in_data & gin_reg;
    wire         cap_out    = cap_now & in_data & ~gin_reg;

    // A busy channel is refused; block end clears both directions, so only the other direction's activation meets it, and set wins
    wire [NCHAN-1:0] in_act_next   = (in_act_reg & ~fin_sel) | in_set;
    wire [NCHAN-1:0] out_act_next  = (out_act_reg & ~fin_sel) | out_set;
    wire [NCHAN-1:0] func_sel      = act_func_i ? asel : '0;
    wire [NCHAN-1:0] out_func_next = (act_ok & act_out_i) ? ((out_func_reg & ~asel) | func_sel) : out_func_reg;

    // Acknowledge next values; a new word end beats the clear
    wire [NCHAN-1:0] in_ack_next   = (in_ack_reg & in_req_lvl) | in_done;
    wire [NCHAN-1:0] out_ack_next  = (out_ack_reg & out_req_lvl) | out_done;

    // Sequencer: control word access, then one data access per word
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= '0;
            gchan_reg <= 4'h0;
            gin_reg   <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= '0;
                    if (any_pend) begin
                        state_reg <= ST_CW;
                        gchan_reg <= top[4:1];
                        gin_reg   <= top[0];
                    end
                end
                ST_CW: begin
                    cnt_reg <= acc_end ? '0 : cnt_reg + CNT_W'(1);
                    if (acc_end)
                        state_reg <= ST_DATA;
                end
                ST_DATA: begin
                    cnt_reg <= acc_end ? '0 : cnt_reg + CNT_W'(1);
                    if (acc_end)
                        state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Storage address, strobes and the halves of the data register
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mem_addr_reg <= 15'h0000;
            mem_rd_reg   <= 1'b0;
            mem_wr_reg   <= 1'b0;
        end else begin
            mem_rd_reg <= start_cw | cw_end;
            mem_wr_reg <= wr_now;
            if (start_cw)
                mem_addr_reg <= cw_addr;
            else if (cw_end)
                mem_addr_reg <= cur_addr_reg;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_upper_half_reg <= 15'h0000;
            data_lower_half_reg <= 15'h0000;
            cur_addr_reg        <= 15'h0000;
            last_reg            <= 1'b0;
        end else if (cap_cw) begin
            data_upper_half_reg <= rd_upper;
            data_lower_half_reg <= lower_inc;
            cur_addr_reg        <= rd_lower;
            last_reg            <= hit_end;
        end else if (cap_in) begin
            data_upper_half_reg <= in_gated[`IOC_WORD_W-1:`IOC_HALF_W];
            data_lower_half_reg <= in_gated[`IOC_HALF_W-1:0];
        end else if (cap_now) begin
            data_upper_half_reg <= rd_upper;
            data_lower_half_reg <= rd_lower;
        end
    end

    // Restore writes back whatever the data register holds
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i)
            mem_wdata_reg <= '0;
        else if (wr_now)
            mem_wdata_reg <= {data_upper_half_reg, data_lower_half_reg};
    end

    // Output registers load directly from the storage read
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            peripheral_output_reg    <= '0;
            intercomputer_output_reg <= '0;
        end else if (cap_out) begin
            if (is_ic)
                intercomputer_output_reg <= mem_rdata_i;
            else
                peripheral_output_reg <= mem_rdata_i;
        end
    end

    // All groups carry the same word; the far end picks its own channel
    generate
        for (g = 0; g < `IOC_NGROUPS; g++) begin : g_grp
            always_ff @(posedge clk_sys_i or negedge rstn_i) begin
                if (!rstn_i)
                    periph_drv_reg[g] <= '0;
                else
                    periph_drv_reg[g] <= peripheral_output_reg;
            end
            assign periph_grp_o[g] = periph_drv_reg[g];
        end
    endgenerate

    // Acknowledge stays up until the request is seen low; set wins
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            in_ack_reg  <= '0;
            out_ack_reg <= '0;
        end else begin
            in_ack_reg  <= in_ack_next;
            out_ack_reg <= out_ack_next;
        end
    end

    // Channel activation and end of block
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            in_act_reg      <= '0;
            out_act_reg     <= '0;
            out_func_reg    <= '0;
            act_taken_reg   <= 1'b0;
            act_refused_reg <= 1'b0;
        end else begin
            in_act_reg      <= in_act_next;
            out_act_reg     <= out_act_next;
            act_taken_reg   <= act_ok;
            act_refused_reg <= act_valid_i & ~act_ok;
            out_func_reg    <= out_func_next;
        end
    end

    assign act_taken_o   = act_taken_reg;
    assign act_refused_o = act_refused_reg;
    assign in_busy_o     = in_act_reg;
    assign out_busy_o    = out_act_reg;
    assign in_ack_o      = in_ack_reg;
    assign out_ack_o     = out_ack_reg;
    assign out_func_o    = out_func_reg;
    assign ic_data_o     = intercomputer_output_reg;
    assign mem_addr_o    = mem_addr_reg;
    assign mem_rd_o      = mem_rd_reg;
    assign mem_wr_o      = mem_wr_reg;
    assign mem_wdata_o   = mem_wdata_reg;

endmodule // io_channel_block_transfer

// *** io_channel_defs.svh ***
// Constants of the channel block transfer logic
`ifndef IO_CHANNEL_DEFS_SVH
`define IO_CHANNEL_DEFS_SVH

`define IOC_NCHAN      14
`define IOC_CHAN_W     4
`define IOC_WORD_W     30
`define IOC_HALF_W     15
`define IOC_IC_CHANS   2
`define IOC_NGROUPS    3
`define IOC_GRP_CHANS  4
`define IOC_CLK_NS     40
`define IOC_STORE_NS   8000
`define IOC_STORE_CYC  ((`IOC_STORE_NS) / (`IOC_CLK_NS))
`define IOC_CW_BASE    15'h0000

`endif

// *** io_channel_pkg.sv ***
// Types of the channel block transfer logic
`include "io_channel_defs.svh"

package io_channel_pkg;
    typedef logic [`IOC_WORD_W-1:0] word_t;
    typedef logic [`IOC_HALF_W-1:0] half_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CW,
        ST_DATA
    } xfer_state_t;
endpackage

// *** io_channel_properties.sv ***
// Port checker of the channel block transfer engine
`timescale 1ns/1ps
`include "io_channel_defs.svh"
module io_channel_checker #(parameter int STORE_CYC = 200) (
    input wire logic                  clk_sys_i, rstn_i, act_valid_i, act_out_i, act_taken_o, act_refused_o,
    input wire logic [3:0]            act_chan_i,
    input wire logic [13:0]           in_busy_o, out_busy_o, in_req_i, in_ack_o, out_req_i, out_ack_o,
    input wire logic                  mem_rd_o, mem_wr_o,
    input io_channel_pkg::half_t      mem_addr_o,
    input io_channel_pkg::word_t      mem_wdata_o, mem_rdata_i,
    input io_channel_pkg::word_t      periph_grp_o [`IOC_NGROUPS]
);
    import io_channel_pkg::*;
    logic [15:0] since_reg;
    logic        seen_reg, wrote_reg, rd_d_reg;
    half_t       rd_addr_reg;
    word_t       rd_word_reg;
    logic [27:0] ack_prev_reg, busy_prev_reg;
    wire  [27:0] ack_rise = {in_ack_o, out_ack_o} & ~ack_prev_reg;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            since_reg <= 16'h0000;
            seen_reg <= 1'b0;
            wrote_reg <= 1'b0;
            rd_d_reg <= 1'b0;
            rd_addr_reg <= 15'h0000;
            rd_word_reg <= 30'h0;
            ack_prev_reg <= 28'h0;
            busy_prev_reg <= 28'h0;
        end else begin
            rd_d_reg <= mem_rd_o;
            ack_prev_reg <= {in_ack_o, out_ack_o};
            busy_prev_reg <= {in_busy_o, out_busy_o};
            wrote_reg <= mem_rd_o ? 1'b0 : (wrote_reg | mem_wr_o);
            // Memory word is valid only one cycle after the read strobe
            if (rd_d_reg) rd_word_reg <= mem_rdata_i;
            if (mem_rd_o) begin
                since_reg <= 16'h0001;
                seen_reg <= 1'b1;
                rd_addr_reg <= mem_addr_o;
            end else if (since_reg != 16'hFFFF) since_reg <= since_reg + 16'h0001;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    chk_refuse_range: assert property (act_valid_i && act_chan_i > 4'hD |=> act_refused_o && !act_taken_o)
        else $error("channel number out of range not refused");
    chk_refuse_busy: assert property (act_valid_i && act_chan_i < 4'hE && (act_out_i ? out_busy_o[act_chan_i] : in_busy_o[act_chan_i]) |=> act_refused_o)
        else $error("busy channel not refused");
    chk_take_free: assert property (act_valid_i && act_chan_i < 4'hE && !(act_out_i ? out_busy_o[act_chan_i] : in_busy_o[act_chan_i]) |=> act_taken_o && ((($past(act_out_i) ? out_busy_o : in_busy_o) & (14'h1 << $past(act_chan_i))) != 14'h0))
        else $error("free channel not taken and made busy");
    chk_grp_copies: assert property (periph_grp_o[0] == periph_grp_o[1] && periph_grp_o[1] == periph_grp_o[2])
        else $error("driver groups differ");
    chk_access_gap: assert property (mem_rd_o && seen_reg |-> since_reg >= STORE_CYC)
        else $error("storage access overlap");
    chk_restore_done: assert property (mem_rd_o && seen_reg |-> wrote_reg)
        else $error("read not restored before next access");
    chk_wr_addr: assert property (mem_wr_o |-> mem_addr_o == rd_addr_reg && since_reg < STORE_CYC)
        else $error("restore address or time wrong");
    chk_cw_bump: assert property (mem_wr_o && mem_addr_o < 15'h001C |-> mem_wdata_o == {rd_word_reg[29:15], rd_word_reg[14:0] + 15'h0001})
        else $error("control word not advanced");
    chk_busy_end: assert property ((busy_prev_reg & ~{in_busy_o, out_busy_o} & ~ack_rise) == 28'h0)
        else $error("busy cleared without final word");
    chk_one_grant: assert property ($onehot0(ack_rise))
        else $error("two words granted at once");
    chk_ack_cause: assert property ((ack_rise & ~({in_req_i, out_req_i} & busy_prev_reg)) == 28'h0)
        else $error("ack without request on active channel");
endmodule // io_channel_checker
bind io_channel_block_transfer io_channel_checker #(.STORE_CYC(STORE_CYC)) chk (.clk_sys_i, .rstn_i, .act_valid_i,
    .act_out_i, .act_taken_o, .act_refused_o, .act_chan_i, .in_busy_o, .out_busy_o, .in_req_i, .in_ack_o,
    .out_req_i, .out_ack_o, .mem_rd_o, .mem_wr_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .periph_grp_o);

// *** io_channel_far_end.sv ***
// Far-end equipment and core storage model
`timescale 1ns/1ps
module io_channel_far_end (
    input  wire logic                  clk_sys_i,
    input  wire logic [13:0]           in_en_i, out_en_i, in_ack_i, out_ack_i,
    input  wire logic                  mem_rd_i, mem_wr_i,
    input  io_channel_pkg::half_t      mem_addr_i,
    input  io_channel_pkg::word_t      mem_wdata_i, ic_data_i,
    input  io_channel_pkg::word_t      periph_grp_i [3],
    output logic [13:0]                in_req_o, out_req_o,
    output io_channel_pkg::word_t      in_data_o [14],
    output io_channel_pkg::word_t      mem_rdata_o
);
    import io_channel_pkg::*;
    word_t      mem [1024];
    word_t      got_q [$];
    logic [4:0] who_q [$];
    logic [7:0] cnt [14];
    initial begin
        foreach (mem[i]) mem[i] = 30'h0;
        foreach (cnt[i]) cnt[i] = 8'h00;
        in_req_o = 14'h0;
        out_req_o = 14'h0;
        mem_rdata_o = 30'h0;
    end
    // Released data lines show the inverse so a late sample is caught
    always_comb for (int c = 0; c < 14; c++) in_data_o[c] = in_req_o[c] ? {4'hA, 4'(c), 14'h0, cnt[c]} : ~{4'hA, 4'(c), 14'h0, cnt[c]};
    always @(posedge clk_sys_i) begin
        mem_rdata_o <= mem_rd_i ? mem[mem_addr_i[9:0]] : ~mem_rdata_o;
        if (mem_wr_i) mem[mem_addr_i[9:0]] <= mem_wdata_i;
        for (int c = 0; c < 14; c++) begin
            if (in_req_o[c] && (in_ack_i[c] || !in_en_i[c])) begin
                in_req_o[c] <= 1'b0;
                if (in_ack_i[c]) got_q.push_back(in_data_o[c]);
                if (in_ack_i[c]) who_q.push_back({1'b1, 4'(c)});
                if (in_ack_i[c]) cnt[c] <= cnt[c] + 8'h01;
            end else if (!in_req_o[c] && !in_ack_i[c] && in_en_i[c]) in_req_o[c] <= 1'b1;
            if (out_req_o[c] && (out_ack_i[c] || !out_en_i[c])) begin
                out_req_o[c] <= 1'b0;
                // Channels 2-13 listen to their own group only; channels 0-1 take the intercomputer word
                if (out_ack_i[c]) got_q.push_back(c < 2 ? ic_data_i : periph_grp_i[(c - 2) / 4]);
                if (out_ack_i[c]) who_q.push_back({1'b0, 4'(c)});
            end else if (!out_req_o[c] && !out_ack_i[c] && out_en_i[c]) out_req_o[c] <= 1'b1;
        end
    end
endmodule // io_channel_far_end

// *** tb_top.sv ***
// Testbench of the channel block transfer engine
`timescale 1ns/1ps
`include "io_channel_defs.svh"
module tb_top;
    import io_channel_pkg::*;
    logic        clk_sys_i = 1'b0, rstn_i = 1'b0, act_valid_i = 1'b0, act_out_i = 1'b0, act_func_i = 1'b0;
    logic [3:0]  act_chan_i = 4'h0;
    logic [13:0] in_en = 14'h0, out_en = 14'h0;
    logic        act_taken_o, act_refused_o, mem_rd_o, mem_wr_o;
    logic [13:0] in_busy_o, out_busy_o, in_req_i, in_ack_o, out_req_i, out_ack_o, out_func_o;
    word_t       in_data_i [14], periph_grp_o [`IOC_NGROUPS], ic_data_o, mem_wdata_o, mem_rdata_i;
    half_t       mem_addr_o;
    int          n_fail = 0, num_checks = 0, cycles = 0;
    always #20 clk_sys_i = ~clk_sys_i;
    // Short storage cycle keeps the run brief
    io_channel_block_transfer #(.STORE_CYC(10)) dut (.clk_sys_i, .rstn_i, .act_valid_i, .act_out_i, .act_chan_i,
        .act_func_i, .act_taken_o, .act_refused_o, .in_busy_o, .out_busy_o, .in_req_i, .in_data_i, .in_ack_o,
        .out_req_i, .out_ack_o, .out_func_o, .periph_grp_o, .ic_data_o, .mem_addr_o, .mem_rd_o, .mem_wr_o,
        .mem_wdata_o, .mem_rdata_i);
    io_channel_far_end far (.clk_sys_i, .in_en_i(in_en), .out_en_i(out_en), .in_ack_i(in_ack_o),
        .out_ack_i(out_ack_o), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o), .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .ic_data_i(ic_data_o), .periph_grp_i(periph_grp_o), .in_req_o(in_req_i),
        .out_req_o(out_req_i), .in_data_o(in_data_i), .mem_rdata_o(mem_rdata_i));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic act(input logic o, input logic [3:0] ch, input logic f, input logic take);
        @(posedge clk_sys_i);
        act_valid_i <= 1'b1;
        act_out_i <= o;
        act_chan_i <= ch;
        act_func_i <= f;
        @(posedge clk_sys_i);
        act_valid_i <= 1'b0;
        #1;
        cmp({act_taken_o, act_refused_o}, {take, !take});
    endtask
    task automatic cw(input logic o, input logic [3:0] ch, input half_t lo, input half_t hi);
        far.mem[2 * ch + !o] = {hi, lo};
    endtask
    task automatic run(input logic [13:0] i, input logic [13:0] o);
        far.got_q.delete();
        far.who_q.delete();
        in_en <= i;
        out_en <= o;
        @(posedge clk_sys_i);
        for (int k = 0; k < 2000 && (in_busy_o | out_busy_o) !== 14'h0; k++) @(posedge clk_sys_i);
        repeat (8) @(posedge clk_sys_i);
        in_en <= 14'h0;
        out_en <= 14'h0;
        #1;
        cmp({in_busy_o, out_busy_o}, 28'h0);
    endtask
    task automatic t_busy();
        cw(1, 4'h4, 15'h0200, 15'h0201);
        far.mem[10'h200] = 30'h2AAA5555;
        act(1, 4'hE, 0, 0);
        act(1, 4'h4, 0, 1);
        act(1, 4'h4, 0, 0);
        cmp(out_busy_o, 14'h0010);
        run(14'h0, 14'h0010);
        cmp(far.got_q[0], 30'h2AAA5555);
        $display("test busy done");
    endtask
    task automatic t_block();
        cw(1, 4'h6, 15'h0210, 15'h0213);
        for (int k = 0; k < 3; k++) far.mem[10'h210 + k] = 30'h1ABC000 + k;
        act(1, 4'h6, 1, 1);
        cmp(out_func_o, 14'h0040);
        run(14'h0, 14'h0040);
        cmp(far.got_q.size(), 3);
        for (int k = 0; k < 3; k++) begin
            cmp(far.got_q[k], 30'h1ABC000 + k);
            cmp(far.mem[10'h210 + k], 30'h1ABC000 + k);
        end
        cmp(far.mem[12], {15'h0213, 15'h0213});
        $display("test block done");
    endtask
    task automatic trio(input logic o);
        logic [3:0]  ch [3];
        logic [13:0] m;
        int          a;
        word_t       e;
        if (o) begin
            ch[0] = 4'hD;
            ch[1] = 4'h9;
            ch[2] = 4'h1;
        end else begin
            ch[0] = 4'hC;
            ch[1] = 4'h7;
            ch[2] = 4'h0;
        end
        m = 14'h0;
        for (int k = 0; k < 3; k++) begin
            a = (o ? 'h340 : 'h300) + 4 * ch[k];
            cw(o, ch[k], 15'(a), 15'(a + 1));
            far.mem[a] = {4'h5, ch[k], 22'h1};
            m = m | (14'h1 << ch[k]);
            act(o, ch[k], 0, 1);
        end
        run(o ? 14'h0 : m, o ? m : 14'h0);
        for (int k = 0; k < 3; k++) begin
            a = (o ? 'h340 : 'h300) + 4 * ch[k];
            e = o ? {4'h5, ch[k], 22'h1} : {4'hA, ch[k], 22'h0};
            cmp(far.who_q[k], {!o, ch[k]});
            cmp(far.got_q[k], e);
            cmp(far.mem[a], e);
        end
    endtask
    task automatic t_in_prio();
        trio(0);
        $display("test input priority done");
    endtask
    task automatic t_out_prio();
        trio(1);
        $display("test output priority done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        t_busy();
        t_block();
        t_in_prio();
        t_out_prio();
        final_report();
    end
    // Whole run needs well under a thousand cycles
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            final_report();
        end
    end
endmodule // tb_top
